// ===== src/smcc_checker.sv
// Purpose: Validates mailbox channel and watchdog settings, runs the node state
// Assumes: Master keeps strobes one cycle long and never both at once
// Notes: Errors latch until acknowledged through the AL control register
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ns
module smcc_checker #(
  parameter int BLINK_CYCLES = smcc_pkg::BLINK_CYC
)(
  input wire logic core_clk,
  input wire logic nrst,
  input wire smcc_pkg::smcc_req_s bus_req,
  output logic [smcc_pkg::DW-1:0] rdata,
  output logic irq,
  output logic err_led,
  output logic [3:0] node_state
);
  import smcc_pkg::*;

  if (BLINK_CYCLES < 2)
  begin : g_chk
    $error("BLINK_CYCLES must be at least 2");
  end

  ////////////////////////////////////////////////////////////////////////////
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [DW-1:0] wd_div, wd_time, rx_start, rx_len, tx_start, tx_len;
  logic [DW-1:0] cycle_us, pd_start, pd_end, al_code;
  logic [7:0] rx_ctrl, tx_ctrl;
  logic [1:0] sync_mode;
  logic [EV_W-1:0] irq_stat, irq_mask, ev;
  logic mb_err, wd_err, set_mb, set_wd;
  smcc_state_e state, next_state;

  wire wr_en = bus_req.wr;
  wire req = wr_en && bus_req.addr == AL_CTRL_ADDR;
  wire [3:0] req_code = bus_req.wdata[3:0];
  wire clr = req && bus_req.wdata[ACK_BIT];
  wire err_any = mb_err || wd_err;
  wire stat_rd = bus_req.rd && bus_req.addr == IRQ_STAT_ADDR;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wd_div <= '0;
      wd_time <= '0;
      rx_start <= '0;
      rx_len <= '0;
      rx_ctrl <= '0;
      tx_start <= '0;
      tx_len <= '0;
      tx_ctrl <= '0;
      sync_mode <= SYNC_FREERUN;
      cycle_us <= '0;
      pd_start <= '0;
      pd_end <= '0;
      irq_mask <= '0;
    end
    else if (wr_en)
    begin
      case (bus_req.addr)
        WD_DIV_ADDR: wd_div <= bus_req.wdata;
        WD_TIME_ADDR: wd_time <= bus_req.wdata;
        RX_START_ADDR: rx_start <= bus_req.wdata;
        RX_LEN_ADDR: rx_len <= bus_req.wdata;
        RX_CTRL_ADDR: rx_ctrl <= bus_req.wdata[7:0];
        TX_START_ADDR: tx_start <= bus_req.wdata;
        TX_LEN_ADDR: tx_len <= bus_req.wdata;
        TX_CTRL_ADDR: tx_ctrl <= bus_req.wdata[7:0];
        SYNC_MODE_ADDR: sync_mode <= bus_req.wdata[1:0];
        CYCLE_ADDR: cycle_us <= bus_req.wdata;
        PD_START_ADDR: pd_start <= bus_req.wdata;
        PD_END_ADDR: pd_end <= bus_req.wdata;
        IRQ_MASK_ADDR: irq_mask <= bus_req.wdata[EV_W-1:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Half-open byte ranges; ends carry a 17th bit so no wrap at 64k
  function automatic logic overlap(input logic [DW:0] a_s, input logic [DW:0] a_e,
                                   input logic [DW:0] b_s, input logic [DW:0] b_e);
    overlap = (a_s < b_e) && (b_s < a_e);
  endfunction

  logic [DW:0] rx_end, tx_end;
  assign rx_end = {1'b0, rx_start} + {1'b0, rx_len};
  assign tx_end = {1'b0, tx_start} + {1'b0, tx_len};

  logic mb_bad;
  always_comb
  begin
    mb_bad = 1'b0;
    if (overlap({1'b0, rx_start}, rx_end, {1'b0, tx_start}, tx_end))
      mb_bad = 1'b1;
    if (overlap({1'b0, rx_start}, rx_end, {1'b0, pd_start}, {1'b0, pd_end})
        || overlap({1'b0, tx_start}, tx_end, {1'b0, pd_start}, {1'b0, pd_end}))
      mb_bad = 1'b1;
    if (rx_start[0] || tx_start[0])
      mb_bad = 1'b1;
    if (rx_len < MIN_MBX_LEN)
      mb_bad = 1'b1;
    if (tx_len < MIN_MBX_LEN)
      mb_bad = 1'b1;
    if (rx_ctrl[CTRL_CODE_W-1:0] != RX_CTRL_CODE)
      mb_bad = 1'b1;
    if (tx_ctrl[CTRL_CODE_W-1:0] != TX_CTRL_CODE)
      mb_bad = 1'b1;
  end

  // Timeout in ns: (divider + offset) * base tick * count
  logic [47:0] wd_timeout_ns, cycle_limit_ns;
  assign wd_timeout_ns = 48'(({32'h0, wd_div} + 48'(WD_DIV_OFFSET)) * 48'(WD_BASE_NS)
                         * {32'h0, wd_time});
  assign cycle_limit_ns = 48'({32'h0, cycle_us} * 48'(1000) * 48'(CYCLE_FACTOR));

  logic wd_bad;
  always_comb
  begin
    wd_bad = 1'b0;
    if (rx_ctrl[WD_TRIG_BIT])
    begin
      if (sync_mode == SYNC_FREERUN)
        wd_bad = wd_timeout_ns < 48'(FREERUN_MIN_NS);
      else
        wd_bad = wd_timeout_ns < cycle_limit_ns;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Requests are ignored while an error is latched, except a drop to Init from any state but Boot
  always_comb
  begin
    next_state = state;
    set_mb = 1'b0;
    set_wd = 1'b0;
    if (mb_bad && (state != SMCC_INIT || (req && !err_any
        && (req_code == REQ_PREOP || req_code == REQ_BOOT))))
    begin
      next_state = SMCC_INIT;
      set_mb = 1'b1;
    end
    else if (req && err_any)
    begin
      if (req_code == REQ_INIT && state != SMCC_BOOT)
        next_state = SMCC_INIT;
    end
    else if (req)
    begin
      case (state)
        SMCC_INIT:
          if (req_code == REQ_PREOP)
            next_state = SMCC_PREOP;
          else if (req_code == REQ_BOOT)
            next_state = SMCC_BOOT;
        SMCC_PREOP:
          if (req_code == REQ_INIT)
            next_state = SMCC_INIT;
          else if (req_code == REQ_SAFEOP && wd_bad)
            set_wd = 1'b1;
          else if (req_code == REQ_SAFEOP)
            next_state = SMCC_SAFEOP;
        SMCC_SAFEOP:
          if (req_code == REQ_INIT)
            next_state = SMCC_INIT;
          else if (req_code == REQ_PREOP)
            next_state = SMCC_PREOP;
          else if (req_code == REQ_OP)
            next_state = SMCC_OP;
        SMCC_OP:
          if (req_code == REQ_INIT)
            next_state = SMCC_INIT;
          else if (req_code == REQ_PREOP)
            next_state = SMCC_PREOP;
          else if (req_code == REQ_SAFEOP)
            next_state = SMCC_SAFEOP;
        SMCC_BOOT:
          if (req_code == REQ_INIT)
            next_state = SMCC_INIT;
        default: next_state = SMCC_INIT;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      state <= SMCC_INIT;
    else
      state <= next_state;
  end

  // New error wins over an acknowledge in the same cycle
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mb_err <= 1'b0;
      wd_err <= 1'b0;
      al_code <= CODE_NONE;
    end
    else
    begin
      mb_err <= set_mb || (mb_err && !clr);
      wd_err <= set_wd || (wd_err && !clr);
      if (set_mb)
        al_code <= CODE_MBX;
      else if (set_wd)
        al_code <= CODE_WD;
      else if (clr)
        al_code <= CODE_NONE;
    end
  end

  function automatic logic [3:0] state_code(input smcc_state_e s);
    case (s)
      SMCC_PREOP: state_code = REQ_PREOP;
      SMCC_BOOT: state_code = REQ_BOOT;
      SMCC_SAFEOP: state_code = REQ_SAFEOP;
      SMCC_OP: state_code = REQ_OP;
      default: state_code = REQ_INIT;
    endcase
  endfunction

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      node_state <= REQ_INIT;
    else
      node_state <= state_code(next_state);
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [31:0] blink_cnt;
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      blink_cnt <= '0;
      err_led <= 1'b0;
    end
    else if (!err_any)
    begin
      blink_cnt <= '0;
      err_led <= 1'b0;
    end
    else if (blink_cnt == 32'(BLINK_CYCLES - 1))
    begin
      blink_cnt <= '0;
      err_led <= !err_led;
    end
    else
      blink_cnt <= blink_cnt + 32'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  assign ev = {next_state != state, set_wd, set_mb};

  // Event in the read cycle stays set
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_stat <= '0;
      irq <= 1'b0;
    end
    else
    begin
      irq_stat <= ev | (stat_rd ? '0 : irq_stat);
      irq <= |(irq_stat & irq_mask);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata <= '0;
    else if (bus_req.rd)
    begin
      case (bus_req.addr)
        WD_DIV_ADDR: rdata <= wd_div;
        WD_TIME_ADDR: rdata <= wd_time;
        RX_START_ADDR: rdata <= rx_start;
        RX_LEN_ADDR: rdata <= rx_len;
        RX_CTRL_ADDR: rdata <= {8'h00, rx_ctrl};
        TX_START_ADDR: rdata <= tx_start;
        TX_LEN_ADDR: rdata <= tx_len;
        TX_CTRL_ADDR: rdata <= {8'h00, tx_ctrl};
        AL_STAT_ADDR: rdata <= {10'h000, wd_err, mb_err, state_code(state)};
        AL_CODE_ADDR: rdata <= al_code;
        SYNC_MODE_ADDR: rdata <= {14'h0000, sync_mode};
        CYCLE_ADDR: rdata <= cycle_us;
        PD_START_ADDR: rdata <= pd_start;
        PD_END_ADDR: rdata <= pd_end;
        IRQ_STAT_ADDR: rdata <= {13'h0000, irq_stat};
        IRQ_MASK_ADDR: rdata <= {13'h0000, irq_mask};
        default: rdata <= '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_rx_len_drop:
  assert property (@(posedge core_clk) disable iff (!rst_n)
    (state == SMCC_PREOP && rx_len < MIN_MBX_LEN) |=> state == SMCC_INIT && mb_err)
    else $error("short rx mailbox not rejected");
  a_tx_ctrl_drop:
  assert property (@(posedge core_clk) disable iff (!rst_n)
    (state == SMCC_OP && tx_ctrl[CTRL_CODE_W-1:0] != TX_CTRL_CODE) |=> state == SMCC_INIT)
    else $error("bad tx control code not rejected");
  a_odd_start_drop:
  assert property (@(posedge core_clk) disable iff (!rst_n)
    (state == SMCC_SAFEOP && (rx_start[0] || tx_start[0])) |=> mb_err)
    else $error("odd mailbox start not rejected");
  a_mbx_code:
  assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(mb_err) |-> al_code == CODE_MBX && node_state == REQ_INIT)
    else $error("mailbox error code or state wrong");
  a_wd_stay_preop:
  assert property (@(posedge core_clk) disable iff (!rst_n)
    (state == SMCC_PREOP && req && req_code == REQ_SAFEOP && !err_any && !mb_bad && wd_bad)
    |=> state == SMCC_PREOP && wd_err && al_code == CODE_WD)
    else $error("watchdog failure not held in PreOP");
  a_wd_trig_off:
  assert property (@(posedge core_clk) disable iff (!rst_n)
    (state == SMCC_PREOP && req && req_code == REQ_SAFEOP && !err_any && !mb_bad
     && !rx_ctrl[WD_TRIG_BIT]) |=> state == SMCC_SAFEOP)
    else $error("watchdog checked while trigger off");
  a_err_latched:
  assert property (@(posedge core_clk) disable iff (!rst_n)
    (err_any && !clr) |=> err_any && ($stable(al_code) || al_code == CODE_MBX))
    else $error("error dropped without clear");
  a_led_idle:
  assert property (@(posedge core_clk) disable iff (!rst_n)
    !err_any ##1 !err_any |-> !err_led)
    else $error("indicator lit without error");
  a_irq_level:
  assert property (@(posedge core_clk) disable iff (!rst_n)
    set_mb && irq_mask[EV_MBX] && !(wr_en && bus_req.addr == IRQ_MASK_ADDR) |=> ##1 irq)
    else $error("interrupt output mismatch");
endmodule

// ===== src/smcc_pkg.sv
// Purpose: Shared constants and types of the sync manager config checker
// Assumes: 16-bit register port, printed offsets used as addresses
// Notes: Extra control registers sit in the 0xf00 page
package smcc_pkg;
  localparam int AW = 12;
  localparam int DW = 16;
  // Register offsets
  localparam logic [AW-1:0] WD_DIV_ADDR = 12'h400;
  localparam logic [AW-1:0] WD_TIME_ADDR = 12'h420;
  localparam logic [AW-1:0] RX_START_ADDR = 12'h800;
  localparam logic [AW-1:0] RX_LEN_ADDR = 12'h802;
  localparam logic [AW-1:0] RX_CTRL_ADDR = 12'h804;
  localparam logic [AW-1:0] TX_START_ADDR = 12'h808;
  localparam logic [AW-1:0] TX_LEN_ADDR = 12'h80a;
  localparam logic [AW-1:0] TX_CTRL_ADDR = 12'h80c;
  localparam logic [AW-1:0] AL_CTRL_ADDR = 12'hf00;
  localparam logic [AW-1:0] AL_STAT_ADDR = 12'hf02;
  localparam logic [AW-1:0] AL_CODE_ADDR = 12'hf04;
  localparam logic [AW-1:0] SYNC_MODE_ADDR = 12'hf06;
  localparam logic [AW-1:0] CYCLE_ADDR = 12'hf08;
  localparam logic [AW-1:0] PD_START_ADDR = 12'hf0a;
  localparam logic [AW-1:0] PD_END_ADDR = 12'hf0c;
  localparam logic [AW-1:0] IRQ_STAT_ADDR = 12'hf0e;
  localparam logic [AW-1:0] IRQ_MASK_ADDR = 12'hf10;
  // Field layout
  localparam int CTRL_CODE_W = 4;
  localparam int WD_TRIG_BIT = 6;
  localparam int ACK_BIT = 4;
  localparam logic [3:0] RX_CTRL_CODE = 4'h6;
  localparam logic [3:0] TX_CTRL_CODE = 4'h2;
  localparam logic [DW-1:0] MIN_MBX_LEN = 16'h0020;
  // Requested and reported state codes
  localparam logic [3:0] REQ_INIT = 4'h1;
  localparam logic [3:0] REQ_PREOP = 4'h2;
  localparam logic [3:0] REQ_BOOT = 4'h3;
  localparam logic [3:0] REQ_SAFEOP = 4'h4;
  localparam logic [3:0] REQ_OP = 4'h8;
  localparam logic [DW-1:0] CODE_NONE = 16'h0000;
  localparam logic [DW-1:0] CODE_MBX = 16'h0016;
  localparam logic [DW-1:0] CODE_WD = 16'h001f;
  localparam logic [1:0] SYNC_FREERUN = 2'h0;
  // Event bits of the interrupt status
  localparam int EV_MBX = 0;
  localparam int EV_WD = 1;
  localparam int EV_STATE = 2;
  localparam int EV_W = 3;
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int BLINK_MS = 200;
  localparam int BLINK_CYC = BLINK_MS * 1000000 / CLK_PERIOD_NS;
  localparam int FREERUN_MIN_MS = 2;
  localparam longint FREERUN_MIN_NS = FREERUN_MIN_MS * 1000000;
  localparam int WD_BASE_NS = 40;
  localparam int WD_DIV_OFFSET = 2;
  localparam int CYCLE_FACTOR = 2;

  typedef enum logic [4:0] {
    SMCC_INIT = 5'h01,
    SMCC_PREOP = 5'h02,
    SMCC_BOOT = 5'h04,
    SMCC_SAFEOP = 5'h08,
    SMCC_OP = 5'h10
  } smcc_state_e;

  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic wr;
    logic rd;
  } smcc_req_s;
endpackage

// ===== tb/smcc_checker_test.sv
// Purpose: Self-checking bench comparing the checker with a behavioural model
// Assumes: Short blink count, master model drives every register access
// Notes: Mailbox sweep covers all control codes plus random layouts
`timescale 1ns/1ns
`define CHK(g, e) \
  begin \
    samples_checked++; \
    if ((g) !== (e)) \
    begin \
      n_mismatch++; \
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); \
    end \
  end
module smcc_checker_test;
  import smcc_pkg::*;
  localparam int PDS = 16'h1100;
  localparam int PDE = 16'h1200;
  logic core_clk;
  logic nrst;
  smcc_req_s bus_req;
  logic [DW-1:0] rdata;
  logic irq;
  logic err_led;
  logic [3:0] node_state;
  logic [DW-1:0] d;
  int n_mismatch;
  int samples_checked;
  int cycles;
  int rs, rl, rc, ts, tl, tc, blinks, md, dv, tm, cy, lim;
  bit bad;

  smcc_checker #(.BLINK_CYCLES(8)) u_smcc_checker (
    .core_clk(core_clk),
    .nrst(nrst),
    .bus_req(bus_req),
    .rdata(rdata),
    .irq(irq),
    .err_led(err_led),
    .node_state(node_state)
  );

  smcc_master u_smcc_master (
    .core_clk(core_clk),
    .rdata(rdata),
    .bus_req(bus_req)
  );

  ////////////////////////////////////////////////////////////////////////////
  function automatic bit ovl(int a, int al, int b, int bl);
    return a < b + bl && b < a + al;
  endfunction

  function automatic bit mbx_bad();
    return ovl(rs, rl, ts, tl) || ovl(rs, rl, PDS, PDE - PDS) || ovl(ts, tl, PDS, PDE - PDS)
      || rs[0] || ts[0] || rl < 32 || tl < 32 || rc[3:0] != 6 || tc[3:0] != 2;
  endfunction

  task automatic req(input logic [3:0] c, input logic ack);
    u_smcc_master.wr(AL_CTRL_ADDR, {11'h0, ack, c});
  endtask

  task automatic cfg();
    u_smcc_master.wr(RX_START_ADDR, 16'(rs));
    u_smcc_master.wr(RX_LEN_ADDR, 16'(rl));
    u_smcc_master.wr(RX_CTRL_ADDR, 16'(rc));
    u_smcc_master.wr(TX_START_ADDR, 16'(ts));
    u_smcc_master.wr(TX_LEN_ADDR, 16'(tl));
    u_smcc_master.wr(TX_CTRL_ADDR, 16'(tc));
  endtask

  task automatic chk(input logic [3:0] st, input logic [DW-1:0] code, input bit cc);
    repeat (2) @(posedge core_clk);
    #1;
    `CHK(node_state, st)
    if (cc)
    begin
      u_smcc_master.rd(AL_CODE_ADDR, d);
      `CHK(d, code)
    end
  endtask

  task automatic finish_test();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Cut a hang short well after the expected few thousand cycles
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      n_mismatch++;
      finish_test();
    end
  end

  initial
  begin
    nrst = 1'b0;
    void'($urandom(74072));
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (5) @(posedge core_clk);
    u_smcc_master.wr(PD_START_ADDR, 16'(PDS));
    u_smcc_master.wr(PD_END_ADDR, 16'(PDE));
    u_smcc_master.wr(IRQ_MASK_ADDR, 16'h0001);
    for (int i = 0; i < 72; i++)
    begin
      rs = 16'h1000;
      rl = 16'h80;
      rc = 6;
      ts = 16'h1080;
      tl = 16'h80;
      tc = 2;
      if (i < 16)
        rc = i;
      else if (i < 32)
        tc = i - 16;
      else
      begin
        rs = 16'h1000 + $urandom_range(0, 16'h1ff);
        rl = $urandom_range(0, 16'h7f);
        ts = 16'h1080 + $urandom_range(0, 16'h1ff);
        tl = $urandom_range(0, 16'h7f);
        rc = ($urandom_range(0, 3) == 0) ? $urandom_range(0, 255) : 6;
        tc = ($urandom_range(0, 3) == 0) ? $urandom_range(0, 255) : 2;
      end
      req(REQ_INIT, 1'b0);
      req(4'h0, 1'b1);
      cfg();
      req(REQ_PREOP, 1'b0);
      bad = mbx_bad();
      chk(bad ? REQ_INIT : REQ_PREOP, CODE_MBX, bad);
    end
    // Fault while running in PreOP
    rs = 16'h1000;
    rl = 16'h80;
    rc = 6;
    ts = 16'h1080;
    tl = 16'h80;
    tc = 2;
    req(REQ_INIT, 1'b0);
    req(4'h0, 1'b1);
    cfg();
    req(REQ_PREOP, 1'b0);
    chk(REQ_PREOP, CODE_NONE, 1'b0);
    u_smcc_master.rd(IRQ_STAT_ADDR, d);
    u_smcc_master.wr(RX_LEN_ADDR, 16'h001f);
    chk(REQ_INIT, CODE_MBX, 1'b1);
    `CHK(irq, 1'b1)
    u_smcc_master.rd(IRQ_STAT_ADDR, d);
    `CHK(d[EV_MBX], 1'b1)
    repeat (2) @(posedge core_clk);
    #1;
    `CHK(irq, 1'b0)
    blinks = 0;
    repeat (40) @(posedge core_clk) blinks += err_led;
    `CHK(blinks > 8, 1'b1)
    u_smcc_master.wr(RX_LEN_ADDR, 16'h0080);
    req(REQ_PREOP, 1'b0);
    chk(REQ_INIT, CODE_MBX, 1'b1);
    req(4'h0, 1'b1);
    blinks = 0;
    repeat (2) @(posedge core_clk);
    repeat (20) @(posedge core_clk) blinks += err_led;
    `CHK(blinks, 0)
    req(REQ_PREOP, 1'b0);
    chk(REQ_PREOP, CODE_NONE, 1'b0);
    // Watchdog limit against sync mode and cycle
    for (int i = 0; i < 40; i++)
    begin
      md = (i < 6) ? i % 3 : $urandom_range(0, 3);
      dv = (i < 6) ? 0 : $urandom_range(0, 3);
      tm = (i < 6) ? 25000 - i / 3 : $urandom_range(5000, 30000);
      cy = (i < 6) ? 1000 : $urandom_range(100, 1000);
      rc = (i < 6 || $urandom_range(0, 3) != 0) ? 16'h46 : 16'h06;
      lim = (md == 0) ? 2000000 : 2 * cy * 1000;
      req(REQ_PREOP, 1'b0);
      req(4'h0, 1'b1);
      u_smcc_master.wr(SYNC_MODE_ADDR, 16'(md));
      u_smcc_master.wr(CYCLE_ADDR, 16'(cy));
      u_smcc_master.wr(WD_DIV_ADDR, 16'(dv));
      u_smcc_master.wr(WD_TIME_ADDR, 16'(tm));
      u_smcc_master.wr(RX_CTRL_ADDR, 16'(rc));
      req(REQ_SAFEOP, 1'b0);
      bad = rc[6] && (dv + 2) * 40 * tm < lim;
      chk(bad ? REQ_PREOP : REQ_SAFEOP, CODE_WD, bad);
    end
    // Faults while running in SafeOP, OP and Boot
    req(REQ_INIT, 1'b0);
    req(4'h0, 1'b1);
    u_smcc_master.wr(RX_CTRL_ADDR, 16'h0006);
    req(REQ_PREOP, 1'b0);
    req(REQ_SAFEOP, 1'b0);
    chk(REQ_SAFEOP, CODE_NONE, 1'b1);
    u_smcc_master.wr(RX_START_ADDR, 16'h0f01);
    chk(REQ_INIT, CODE_MBX, 1'b1);
    u_smcc_master.wr(RX_START_ADDR, 16'h1000);
    req(4'h0, 1'b1);
    req(REQ_PREOP, 1'b0);
    req(REQ_SAFEOP, 1'b0);
    req(REQ_OP, 1'b0);
    chk(REQ_OP, CODE_NONE, 1'b1);
    u_smcc_master.wr(TX_CTRL_ADDR, 16'h0003);
    chk(REQ_INIT, CODE_MBX, 1'b1);
    u_smcc_master.wr(TX_CTRL_ADDR, 16'h0002);
    u_smcc_master.wr(RX_LEN_ADDR, 16'h0010);
    req(4'h0, 1'b1);
    req(REQ_BOOT, 1'b0);
    chk(REQ_INIT, CODE_MBX, 1'b1);
    u_smcc_master.wr(RX_LEN_ADDR, 16'h0080);
    req(4'h0, 1'b1);
    req(REQ_BOOT, 1'b0);
    chk(REQ_BOOT, CODE_NONE, 1'b1);
    u_smcc_master.wr(RX_CTRL_ADDR, 16'h0007);
    chk(REQ_INIT, CODE_MBX, 1'b1);
    finish_test();
  end
endmodule

// ===== tb/smcc_master.sv
// Purpose: Master side model that programs the checker over the register port
// Assumes: One strobe per cycle, every change right after a rising edge
// Notes: Released data lines carry inverted values so stale data never looks valid
`timescale 1ns/1ns
module smcc_master (
  input wire logic core_clk,
  input wire logic [smcc_pkg::DW-1:0] rdata,
  output smcc_pkg::smcc_req_s bus_req
);
  import smcc_pkg::*;

  initial bus_req = '0;

  ////////////////////////////////////////////////////////////////////////////
  // Strobe held for exactly one sampled edge, then dropped
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    bus_req.wr <= 1'b0;
    bus_req.wdata <= ~d;
  endtask

  // Read data is registered at the edge that samples the strobe and holds until the next read
  task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: bus_req.wdata, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    bus_req.rd <= 1'b0;
    #1;
    d = rdata;
  endtask
endmodule
